// File: rtl/drive_ctl_defines.vh
`ifndef DRIVE_CTL_DEFINES_VH
`define DRIVE_CTL_DEFINES_VH
// Clock period in picoseconds (250 MHz)
`define CLK_PERIOD_PS 4000
// Track range
`define TRACK_MAX 10'd639
`define TRACK_ZERO 10'd0
// Least step spacing, in ns
`define STEP_SPACING_NS 500
// Settled drop delay after first step, in ns
`define SETTLE_DROP_NS 500
`define SETTLE_DROP_CYC ((`SETTLE_DROP_NS * 1000) / `CLK_PERIOD_PS)
// Least settled-low time, in us
`define SETTLE_LOW_US 10000
`define SETTLE_LOW_CYC ((`SETTLE_LOW_US * 1000) / (`CLK_PERIOD_PS / 1000))
// Deselect time that clears the record-error flag, in us
`define DESEL_CLR_US 50
`define DESEL_CLR_CYC ((`DESEL_CLR_US * 1000) / (`CLK_PERIOD_PS / 1000))
// Automatic record-error clear delay, in us
`define ERR_CLR_US 2000
`define ERR_CLR_CYC ((`ERR_CLR_US * 1000) / (`CLK_PERIOD_PS / 1000))
// Power-up phase default lengths, in cycles
`define SPIN_UP_CYC 32'd1000
`define UNLOCK_CYC 32'd100
`endif

// File: rtl/pin_sync3.v
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire srst,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] lvl_q;
  genvar i;

  //////////////////////////////////////////////////////////////////////////
  // Sampling chain
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit agreement filter
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge core_clk)
      begin
        if (srst)
          lvl_q[i] <= 1'b0;
        else if (s2_q[i] == s3_q[i])
          lvl_q[i] <= s3_q[i];
      end
    end
  endgenerate

  assign level_out = lvl_q;
endmodule // pin_sync3

// File: rtl/drive_seek_ctl.v
`timescale 1ns/1ps
`include "drive_ctl_defines.vh"
// Function
// - After supplies good, spin up, release lock, then move heads to track 000.
// - React to step, direction, head and record inputs only when our jumpered select line is active.
// - Status outputs toward controller only while this unit is selected.
// - Each accepted step moves heads one track per direction level, two if accepted in the cycle a pending move completes.
// - Direction asserted means inward; negated means outward toward track 000.
// - Step pulses at 0.5 us spacing are all counted while record enable is off, none lost.
// - Positioning-settled asserts only after heads settle on final track.
// - Binary head number picks one of 2 heads for read and write.
// - Motion starts on step rising edge; direction set 100 ns before.
// - Settled drops about 500 ns after first step; stays low at least 10 ms.
// - Error clears after 50 us deselect, else once no cause is active and fault_cause has been low 2 ms.
// - Track count 000..639; motion stops at either extreme.
module drive_seek_ctl #(
  parameter [1:0] UNIT_ID = 2'd0,
  parameter [31:0] SPIN_UP_CYC = `SPIN_UP_CYC,
  parameter [31:0] UNLOCK_CYC = `UNLOCK_CYC,
  parameter [31:0] SETTLE_LOW_CYC = `SETTLE_LOW_CYC,
  parameter [31:0] DESEL_CLR_CYC = `DESEL_CLR_CYC,
  parameter [31:0] ERR_CLR_CYC = `ERR_CLR_CYC,
  parameter [31:0] MOVE_CYC = 32'd16
) (
  input wire core_clk,
  input wire srst,
  input wire power_good,
  input wire speed_ok,
  input wire [3:0] unit_select,
  input wire step_in,
  input wire dir_in,
  input wire head_choice,
  input wire record_enable,
  input wire fault_cause,
  input wire flux_pattern_input,
  input wire [1:0] head_read_data,
  output reg spindle_run,
  output reg lock_release,
  output reg [1:0] head_write_en,
  output reg [1:0] head_write_data,
  output reg flux_pattern_output,
  output reg [9:0] track_pos,
  output wire ready_out,
  output wire settled_out,
  output wire track0_out,
  output wire rec_error_out,
  output wire selected_out
);
  localparam [3:0] ST_SPIN = 4'b0001;
  localparam [3:0] ST_UNLOCK = 4'b0010;
  localparam [3:0] ST_HOME = 4'b0100;
  localparam [3:0] ST_RUN = 4'b1000;
  localparam [31:0] DROP_CYC = `SETTLE_DROP_CYC;

  wire [7:0] sync_out;
  wire sel_s;
  wire step_s;
  wire dir_s;
  wire rec_s;
  wire head_s;
  wire act;
  wire step_rise;
  reg step_prev_q;
  reg [3:0] state_q;
  reg [31:0] tmr_q;
  reg [9:0] pend_q;
  reg pend_dir_q;
  reg [31:0] move_q;
  reg settled_q;
  reg seeking_q;
  reg [31:0] drop_q;
  reg [31:0] low_q;
  reg err_q;
  reg [31:0] desel_q;
  reg [31:0] errclr_q;

  //////////////////////////////////////////////////////////////////////////
  // Pin inputs from the cable
  pin_sync3 #(
    .WIDTH(8)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in({unit_select, step_in, dir_in, record_enable, head_choice}),
    .level_out(sync_out)
  );

  assign sel_s = sync_out[4 + UNIT_ID];
  assign step_s = sync_out[3];
  assign dir_s = sync_out[2];
  assign rec_s = sync_out[1];
  assign head_s = sync_out[0];
  assign act = sel_s && (state_q == ST_RUN);
  assign step_rise = step_s && !step_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Outputs gated by selection
  assign selected_out = sel_s;
  assign ready_out = sel_s && (state_q == ST_RUN);
  assign settled_out = sel_s && settled_q;
  assign track0_out = sel_s && (track_pos == `TRACK_ZERO);
  assign rec_error_out = sel_s && err_q;

  //////////////////////////////////////////////////////////////////////////
  // Power-up sequence and positioner
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q <= ST_SPIN;
      tmr_q <= 32'd0;
      spindle_run <= 1'b0;
      lock_release <= 1'b0;
      track_pos <= `TRACK_MAX;
      pend_q <= 10'd0;
      pend_dir_q <= 1'b0;
      move_q <= 32'd0;
      step_prev_q <= 1'b0;
    end
    else
    begin
      step_prev_q <= step_s;
      case (state_q)
        ST_SPIN:
        begin
          if (power_good)
          begin
            spindle_run <= 1'b1;
            if (speed_ok && tmr_q >= SPIN_UP_CYC)
            begin
              state_q <= ST_UNLOCK;
              tmr_q <= 32'd0;
            end
            else
              tmr_q <= tmr_q + 32'd1;
          end
        end
        ST_UNLOCK:
        begin
          lock_release <= 1'b1;
          if (tmr_q >= UNLOCK_CYC)
          begin
            state_q <= ST_HOME;
            tmr_q <= 32'd0;
          end
          else
            tmr_q <= tmr_q + 32'd1;
        end
        ST_HOME:
        begin
          // Walk outward one track per move time; dwell one more on 000
          if (tmr_q >= MOVE_CYC)
          begin
            tmr_q <= 32'd0;
            if (track_pos == `TRACK_ZERO)
              state_q <= ST_RUN;
            else
              track_pos <= track_pos - 10'd1;
          end
          else
            tmr_q <= tmr_q + 32'd1;
        end
        ST_RUN:
        begin
          if (!power_good)
            state_q <= ST_SPIN;
          // Buffer each accepted step; a new step lands every fourth cycle at most
          if (act && !rec_s && step_rise)
          begin
            pend_dir_q <= dir_s;
            if (move_q == 32'd0 && pend_q == 10'd0)
              pend_q <= 10'd1;
            else if (pend_q != 10'h3ff)
              pend_q <= pend_q + 10'd1;
          end
          if (pend_q != 10'd0)
          begin
            if (move_q >= MOVE_CYC)
            begin
              move_q <= 32'd0;
              if (!(act && !rec_s && step_rise))
                pend_q <= pend_q - 10'd1;
              if (pend_dir_q && track_pos != `TRACK_MAX)
                track_pos <= track_pos + 10'd1;
              else if (!pend_dir_q && track_pos != `TRACK_ZERO)
                track_pos <= track_pos - 10'd1;
            end
            else
              move_q <= move_q + 32'd1;
          end
        end
        default:
          state_q <= ST_SPIN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Positioning-settled indication
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      settled_q <= 1'b0;
      seeking_q <= 1'b0;
      drop_q <= 32'd0;
      low_q <= 32'd0;
    end
    else if (state_q != ST_RUN)
    begin
      settled_q <= 1'b0;
      seeking_q <= 1'b0;
      low_q <= 32'd0;
    end
    else if (!seeking_q && act && !rec_s && step_rise)
    begin
      seeking_q <= 1'b1;
      drop_q <= 32'd0;
      low_q <= 32'd0;
    end
    else if (seeking_q)
    begin
      if (drop_q < DROP_CYC)
        drop_q <= drop_q + 32'd1;
      else
        settled_q <= 1'b0;
      if (!settled_q || drop_q >= DROP_CYC)
        low_q <= low_q + 32'd1;
      if (pend_q == 10'd0 && low_q >= SETTLE_LOW_CYC)
      begin
        seeking_q <= 1'b0;
        settled_q <= 1'b1;
      end
    end
    else
      settled_q <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Record-error flag
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      err_q <= 1'b0;
      desel_q <= 32'd0;
      errclr_q <= 32'd0;
    end
    else
    begin
      desel_q <= sel_s ? 32'd0 :
        ((desel_q <= DESEL_CLR_CYC) ? desel_q + 32'd1 : desel_q);
      errclr_q <= fault_cause ? 32'd0 :
        ((errclr_q <= ERR_CLR_CYC) ? errclr_q + 32'd1 : errclr_q);
      // A new cause wins over any clear
      if (fault_cause || (act && rec_s && !settled_q))
        err_q <= 1'b1;
      else if (desel_q > DESEL_CLR_CYC)
        err_q <= 1'b0;
      else if (errclr_q >= ERR_CLR_CYC)
        err_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Head routing for read and write
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      head_write_en <= 2'b00;
      head_write_data <= 2'b00;
      flux_pattern_output <= 1'b0;
    end
    else
    begin
      head_write_en <= 2'b00;
      head_write_data <= 2'b00;
      flux_pattern_output <= 1'b0;
      if (act && rec_s && settled_q && !err_q)
      begin
        head_write_en[head_s] <= 1'b1;
        head_write_data[head_s] <= flux_pattern_input;
      end
      else if (act && !rec_s && settled_q)
        flux_pattern_output <= head_read_data[head_s];
    end
  end
endmodule // drive_seek_ctl

// File: dv/drive_seek_ctl_checker.sv
`timescale 1ns/1ps
module drive_seek_ctl_checker #(
  parameter [31:0] SETTLE_LOW_CYC = 32'd50
) (
  input wire core_clk,
  input wire srst,
  input wire spindle_run,
  input wire lock_release,
  input wire [1:0] head_write_en,
  input wire [9:0] track_pos,
  input wire ready_out,
  input wire settled_out,
  input wire track0_out,
  input wire rec_error_out,
  input wire selected_out
);
  reg [31:0] low_q;
  // Cycles spent with settled low
  always @(posedge core_clk)
    low_q <= (srst || settled_out) ? 32'h0 : low_q + 32'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_gate;
    !selected_out |-> !(ready_out | settled_out | track0_out | rec_error_out);
  endproperty
  a_gate: assert property (p_gate) else $error("status out");
  property p_one;
    !$past(srst) && $changed(track_pos) |-> track_pos - $past(track_pos)
      == 10'h1 || $past(track_pos) - track_pos == 10'h1;
  endproperty
  a_one: assert property (p_one) else $error("multi step");
  property p_low;
    $rose(settled_out) && $past(selected_out) |->
      low_q >= SETTLE_LOW_CYC - 32'd1;
  endproperty
  a_low: assert property (p_low) else $error("settle short");
  property p_fin;
    $rose(settled_out) |-> track_pos == $past(track_pos, 4);
  endproperty
  a_fin: assert property (p_fin) else $error("settle moving");
  property p_lock;
    lock_release |-> spindle_run;
  endproperty
  a_lock: assert property (p_lock) else $error("lock order");
  property p_move;
    !$past(srst) && $changed(track_pos) |-> lock_release;
  endproperty
  a_move: assert property (p_move) else $error("moved locked");
  property p_max;
    track_pos <= 10'd639;
  endproperty
  a_max: assert property (p_max) else $error("track range");
  property p_t0;
    track0_out |-> track_pos <= 10'd1;
  endproperty
  a_t0: assert property (p_t0) else $error("track0 wrong");
  property p_head;
    $onehot0(head_write_en);
  endproperty
  a_head: assert property (p_head) else $error("two heads");
  c_rise: cover property ($rose(settled_out));
  c_fall: cover property ($fell(settled_out));
  c_t0: cover property (track0_out);
endmodule // drive_seek_ctl_checker
bind drive_seek_ctl drive_seek_ctl_checker #(
  .SETTLE_LOW_CYC(SETTLE_LOW_CYC)
) u_chk (.core_clk(core_clk), .srst(srst), .spindle_run(spindle_run),
  .lock_release(lock_release), .head_write_en(head_write_en),
  .track_pos(track_pos), .ready_out(ready_out), .settled_out(settled_out),
  .track0_out(track0_out), .rec_error_out(rec_error_out),
  .selected_out(selected_out));

// File: dv/ctl_step_model.sv
`timescale 1ns/1ps
module ctl_step_model (
  input wire core_clk,
  output reg step_in,
  output reg dir_in
);
  initial
  begin
    step_in = 1'b0;
    dir_in = 1'b0;
  end
  // Direction first, then pulses at the least spacing of 125 cycles
  task burst(input integer n, input reg d);
    integer k;
    begin
      @(posedge core_clk) #1 dir_in = d;
      repeat (30) @(posedge core_clk);
      for (k = 0; k < n; k = k + 1)
      begin
        #1 step_in = 1'b1;
        repeat (30) @(posedge core_clk);
        #1 step_in = 1'b0;
        repeat (95) @(posedge core_clk);
      end
      #1;
    end
  endtask
endmodule // ctl_step_model

// File: dv/drive_seek_ctl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared = n_compared + 1; \
  if ((a) !== (e)) begin err_total = err_total + 1; \
  $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module drive_seek_ctl_tb;
  reg core_clk = 1'b0, srst = 1'b1, power_good = 1'b0, speed_ok = 1'b0;
  reg [3:0] unit_select = 4'h0;
  reg head_choice = 1'b0, record_enable = 1'b0, fault_cause = 1'b0;
  reg flux_in = 1'b0;
  reg [1:0] head_read_data = 2'h0;
  wire step_in, dir_in, spindle_run, lock_release, flux_out;
  wire ready_out, settled_out, track0_out, rec_error_out, selected_out;
  wire [1:0] head_write_en, head_write_data;
  wire [9:0] track_pos;
  integer err_total = 0;
  integer n_compared = 0;
  // Controller side and the block with shortened counts
  ctl_step_model u_ctl (.core_clk(core_clk), .step_in(step_in),
    .dir_in(dir_in));
  drive_seek_ctl #(.SPIN_UP_CYC(32'd10),
    .SETTLE_LOW_CYC(32'd1000), .DESEL_CLR_CYC(32'd20),
    .ERR_CLR_CYC(32'd80), .MOVE_CYC(32'd4)) dut (.core_clk(core_clk),
    .srst(srst), .power_good(power_good), .speed_ok(speed_ok),
    .unit_select(unit_select), .step_in(step_in), .dir_in(dir_in),
    .head_choice(head_choice), .record_enable(record_enable),
    .fault_cause(fault_cause), .flux_pattern_input(flux_in),
    .head_read_data(head_read_data), .spindle_run(spindle_run),
    .lock_release(lock_release), .head_write_en(head_write_en),
    .head_write_data(head_write_data), .flux_pattern_output(flux_out),
    .track_pos(track_pos), .ready_out(ready_out),
    .settled_out(settled_out), .track0_out(track0_out),
    .rec_error_out(rec_error_out), .selected_out(selected_out));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      if (err_total == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // Bounded wait for the end of a seek
  task wait_settled;
    integer k;
    begin
      k = 0;
      while (settled_out !== 1'b1 && k < 60000)
      begin
        tick(1);
        k = k + 1;
      end
      if (k == 60000)
      begin
        err_total = err_total + 1;
        end_sim;
      end
    end
  endtask
  task t_power;
    begin
      power_good = 1'b1;
      unit_select = 4'h1;
      tick(30);
      `CHK("spin", 1'b1, spindle_run)
      `CHK("lock", 1'b0, lock_release)
      speed_ok = 1'b1;
      wait_settled;
      `CHK("unlock", 1'b1, lock_release)
      `CHK("home", 10'd0, track_pos)
      `CHK("ready", 1'b1, ready_out)
      `CHK("t0", 1'b1, track0_out)
    end
  endtask
  task t_seek;
    begin
      u_ctl.burst(5, 1'b1);
      `CHK("busy", 1'b0, settled_out)
      wait_settled;
      `CHK("in5", 10'd5, track_pos)
      `CHK("t0off", 1'b0, track0_out)
      u_ctl.burst(2, 1'b0);
      wait_settled;
      `CHK("out2", 10'd3, track_pos)
      u_ctl.burst(5, 1'b0);
      wait_settled;
      `CHK("clamp", 10'd0, track_pos)
    end
  endtask
  task t_ignore;
    begin
      unit_select = 4'h2;
      tick(10);
      `CHK("sel", 1'b0, selected_out)
      `CHK("gate", 4'h0, {ready_out, settled_out, track0_out,
        rec_error_out})
      u_ctl.burst(2, 1'b1);
      unit_select = 4'h1;
      wait_settled;
      `CHK("desel", 10'd0, track_pos)
      record_enable = 1'b1;
      u_ctl.burst(2, 1'b1);
      record_enable = 1'b0;
      wait_settled;
      `CHK("wr", 10'd0, track_pos)
    end
  endtask
  task t_rw;
    begin
      head_choice = 1'b1;
      head_read_data = 2'h2;
      tick(10);
      `CHK("rd1", 1'b1, flux_out)
      head_read_data = 2'h1;
      tick(10);
      `CHK("rd0", 1'b0, flux_out)
      flux_in = 1'b1;
      record_enable = 1'b1;
      tick(10);
      `CHK("wen", 2'h2, head_write_en)
      `CHK("wdat", 2'h2, head_write_data)
      flux_in = 1'b0;
      fault_cause = 1'b1;
      tick(5);
      `CHK("err", 1'b1, rec_error_out)
      fault_cause = 1'b0;
      record_enable = 1'b0;
      tick(10);
      `CHK("errhold", 1'b1, rec_error_out)
      tick(80);
      `CHK("errclr", 1'b0, rec_error_out)
      // Deselect clears the flag well before the automatic clear
      fault_cause = 1'b1;
      tick(2);
      fault_cause = 1'b0;
      `CHK("err2", 1'b1, rec_error_out)
      unit_select = 4'h0;
      tick(30);
      unit_select = 4'h1;
      tick(6);
      `CHK("errdesel", 1'b0, rec_error_out)
    end
  endtask
  // Main sequence
  initial
  begin
    tick(20);
    srst = 1'b0;
    t_power;
    t_seek;
    t_ignore;
    t_rw;
    end_sim;
  end
endmodule // drive_seek_ctl_tb
